// ---- rtl/fld_consts.vh ----
// Purpose: constants for the flash led driver register bank
// Assumes: byte-wide registers on an 8-bit register address
// Notes: definitions only
`ifndef FLD_CONSTS_VH
`define FLD_CONSTS_VH

// register addresses
`define FLD_ADDR_ID 8'h00
`define FLD_ADDR_CUR_A 8'h01
`define FLD_ADDR_CUR_B 8'h02
`define FLD_ADDR_LOWV 8'h04
`define FLD_ADDR_TIMER 8'h05
`define FLD_ADDR_CTRL 8'h06
`define FLD_ADDR_TRIG 8'h07
`define FLD_ADDR_FAULT 8'h08
`define FLD_ADDR_DIM 8'h09
`define FLD_ADDR_MIN 8'h0E
`define FLD_ADDR_ACT 8'h0F
`define FLD_ADDR_KEY 8'h80
`define FLD_ADDR_UPL 8'h81

// reset values
`define FLD_RST_CUR 8'h9C
`define FLD_RST_LOWV 8'h2C
`define FLD_RST_TIMER 8'h23
`define FLD_RST_CTRL 8'h00
`define FLD_RST_TRIG 8'hC0
`define FLD_RST_DIM 8'h00
`define FLD_RST_REPORT 8'h00
`define FLD_RST_UPL 8'h00

// unlock key value
`define FLD_KEY_VALUE 8'hA1

// field positions in the dimming and converter options register and the uplift register
`define FLD_DIM_DUTY_LO 0
`define FLD_DIM_FIXF 2
`define FLD_DIM_A_HI 3
`define FLD_DIM_B_HI 4
`define FLD_DIM_BAL 5
`define FLD_UPL_BIT 0

// operating mode codes
`define FLD_MODE_OFF 2'b00
`define FLD_MODE_IND 2'b01
`define FLD_MODE_ASSIST 2'b10
`define FLD_MODE_FLASH 2'b11

// fixed-frequency current threshold
`define FLD_FIXF_MIN 8'h40

// pwm timing: 31.25 kHz frame split into 16 slots, 125 MHz clock
`define FLD_CLK_KHZ 125000
`define FLD_PWM_KHZ 31250
`define FLD_PWM_SLOTS 16
`define FLD_PWM_SLOT_CYC (`FLD_CLK_KHZ * 1000 / `FLD_PWM_KHZ / `FLD_PWM_SLOTS)

// uplift and trim scale factors in 1/256 units
`define FLD_UPLIFT_MUL 9'd284
`define FLD_TRIM_MAX_Q8 8'd25

`endif

// ---- rtl/fld_pwm.v ----
// Purpose: indicator mode pwm gate, 16 slots per 31.25 kHz frame
// Assumes: 125 MHz clock
// Notes: gate high for duty code + 1 slots of 16
`timescale 1ns/1ps
`include "fld_consts.vh"

module fld_pwm #(
    parameter SLOT_CYC = `FLD_PWM_SLOT_CYC
) (
    input wire clk_i,          // system clock
    input wire srst_i,         // sync reset
    input wire ce_i,           // clock enable
    input wire [1:0] duty_i,   // duty code
    output reg gate_o          // pwm gate
);

    reg [7:0] slot_cnt_r;
    reg [3:0] slot_r;

    // =====================================
    // slot counter and gate
    // =====================================
    // counts slots and compares with duty
    always @(posedge clk_i) begin
        if (srst_i) begin
            slot_cnt_r <= 8'h00;
            slot_r <= 4'h0;
            gate_o <= 1'b0;
        end else if (ce_i) begin
            if (slot_cnt_r == SLOT_CYC - 1) begin
                slot_cnt_r <= 8'h00;
                slot_r <= slot_r + 4'h1;
            end else begin
                slot_cnt_r <= slot_cnt_r + 8'h01;
            end
            gate_o <= (slot_r <= {2'b00, duty_i});
        end
    end
endmodule

// ---- rtl/fld_scale.v ----
// Purpose: applies uplift and load-balance trim to a current code
// Assumes: trim_i signed in 1/256 units, clamped here to +/-10%
// Notes: result saturates at 8'hFF
`timescale 1ns/1ps
`include "fld_consts.vh"

module fld_scale (
    input wire [7:0] code_i,          // programmed code
    input wire uplift_i,              // uplift on
    input wire bal_en_i,              // load balance on
    input wire signed [8:0] trim_i,   // requested trim
    output reg [7:0] code_o           // effective code
);

    reg [16:0] up_w;
    reg [7:0] base_w;
    reg signed [8:0] tr_w;
    reg signed [17:0] sum_w;

    // =====================================
    // scaling math
    // =====================================
    // uplift then bounded trim
    always @* begin
        up_w = uplift_i ? code_i * `FLD_UPLIFT_MUL : {1'b0, code_i, 8'h00};
        base_w = (up_w[16]) ? 8'hFF : up_w[15:8];
        tr_w = trim_i;
        if (tr_w > $signed({1'b0, `FLD_TRIM_MAX_Q8}))
            tr_w = $signed({1'b0, `FLD_TRIM_MAX_Q8});
        if (tr_w < -$signed({1'b0, `FLD_TRIM_MAX_Q8}))
            tr_w = -$signed({1'b0, `FLD_TRIM_MAX_Q8});
        if (!bal_en_i)
            tr_w = 9'sd0;
        sum_w = $signed({10'b0, base_w}) * 18'sd256 + $signed({1'b0, base_w}) * tr_w;
        if (sum_w < 0)
            code_o = 8'h00;
        else if (sum_w[17:8] > 10'h0FF)
            code_o = 8'hFF;
        else
            code_o = sum_w[15:8];
    end
endmodule

// ---- rtl/fld_regs.v ----
// Purpose: register bank for a two-channel flash led driver
// Assumes: register access strobes come from a serial bus decoder on clk_i
// Notes: analog status arrives from outside the clock domain and is synced
`timescale 1ns/1ps
`include "fld_consts.vh"

// Summary of operation
// - indicator pwm 31.25 kHz, duty 1..4/16
// - fixed-frequency clear allows pulse skipping
// - fixed frequency only flash/assist, codes high
// - flag bit3: sink a above b
// - flag bit4: sink b above a
// - load balance trims up to ten percent
// - minimum report holds lowest cycle current
// - minimum updated only on undervoltage reduction
// - reports follow channel a only
// - actual report shows present set current
// - key A1h at 80h unlocks 81h
// - unlock lasts one access only
// - uplift bit raises currents eleven percent
// - indicator uses six low code bits
module fld_regs #(
    parameter [7:0] ID_VALUE = 8'h5A,   // arbitrary identity value
    parameter SLOT_CYC = `FLD_PWM_SLOT_CYC
) (
    input wire clk_i,              // system clock
    input wire srst_i,             // sync reset, active high
    input wire ce_i,               // clock enable
    input wire [7:0] addr_i,       // register address
    input wire wr_i,               // write strobe
    input wire rd_i,               // read strobe
    input wire [7:0] wdata_i,      // write data
    output reg [7:0] rdata_o,      // read data
    input wire a_higher_i,         // async comparator a above b
    input wire b_higher_i,         // async comparator b above a
    input wire conv_run_i,         // async converter running
    input wire uv_reduce_i,        // async undervoltage reduction active
    input wire [7:0] sink_a_now_i, // present sink a code from ramp logic
    input wire signed [8:0] trim_a_i, // balance trim request, channel a
    input wire signed [8:0] trim_b_i, // balance trim request, channel b
    input wire cycle_start_i,      // start of an operating cycle pulse
    input wire [7:0] fault_i,      // fault flags from protection logic
    output reg [1:0] mode_o,       // operating mode
    output reg [7:0] drive_a_o,    // effective code channel a
    output reg [7:0] drive_b_o,    // effective code channel b
    output reg drive_gate_o,       // sink enable incl pwm
    output reg skip_allow_o,       // converter may pulse skip
    output reg [7:0] lowv_o,       // supply low thresholds
    output reg [7:0] timer_o,      // pulse duration limit
    output reg [7:0] trig_o        // trigger input config
);

    reg [7:0] cur_a_r;
    reg [7:0] cur_b_r;
    reg [7:0] ctrl_r;
    reg [7:0] dim_r;
    reg [7:0] min_r;
    reg [7:0] act_r;
    reg upl_r;
    reg unlock_r;
    reg [3:0] s1_r;
    reg [3:0] s2_r;
    reg uv_seen_r;
    wire pwm_gate;
    wire [7:0] eff_a;
    wire [7:0] eff_b;
    wire [7:0] code_a;
    wire [7:0] code_b;
    wire hit_upl;
    wire fixf_ok;

    // =====================================
    // input synchronisers
    // =====================================
    // two stages for analog status
    always @(posedge clk_i) begin
        if (srst_i) begin
            s1_r <= 4'h0;
            s2_r <= 4'h0;
        end else if (ce_i) begin
            s1_r <= {uv_reduce_i, conv_run_i, b_higher_i, a_higher_i};
            s2_r <= s1_r;
        end
    end

    // =====================================
    // register writes
    // =====================================
    assign hit_upl = (addr_i == `FLD_ADDR_UPL);

    // writable registers and unlock state
    always @(posedge clk_i) begin
        if (srst_i) begin
            cur_a_r <= `FLD_RST_CUR;
            cur_b_r <= `FLD_RST_CUR;
            lowv_o <= `FLD_RST_LOWV;
            timer_o <= `FLD_RST_TIMER;
            ctrl_r <= `FLD_RST_CTRL;
            trig_o <= `FLD_RST_TRIG;
            dim_r <= `FLD_RST_DIM;
            upl_r <= 1'b0;
            unlock_r <= 1'b0;
        end else if (ce_i) begin
            if (wr_i) begin
                case (addr_i)
                    `FLD_ADDR_CUR_A: cur_a_r <= wdata_i;
                    `FLD_ADDR_CUR_B: cur_b_r <= wdata_i;
                    `FLD_ADDR_LOWV: lowv_o <= wdata_i;
                    `FLD_ADDR_TIMER: timer_o <= wdata_i;
                    // reserved bit 2 held at zero
                    `FLD_ADDR_CTRL: ctrl_r <= wdata_i & 8'hFB;
                    `FLD_ADDR_TRIG: trig_o <= wdata_i;
                    // flag bits 3 and 4 not stored
                    `FLD_ADDR_DIM: dim_r <= wdata_i & 8'h27;
                    `FLD_ADDR_UPL: begin
                        if (unlock_r)
                            upl_r <= wdata_i[`FLD_UPL_BIT];
                    end
                    default: ;
                endcase
            end
            if (wr_i && addr_i == `FLD_ADDR_KEY)
                unlock_r <= (wdata_i == `FLD_KEY_VALUE);
            else if ((wr_i || rd_i) && hit_upl)
                unlock_r <= 1'b0;
        end
    end

    // =====================================
    // current reports
    // =====================================
    // channel a actual and minimum tracking
    always @(posedge clk_i) begin
        if (srst_i) begin
            act_r <= `FLD_RST_REPORT;
            min_r <= `FLD_RST_REPORT;
            uv_seen_r <= 1'b0;
        end else if (ce_i) begin
            act_r <= sink_a_now_i;
            if (cycle_start_i) begin
                uv_seen_r <= 1'b0;
                min_r <= 8'h00;
            end else if (s2_r[3]) begin
                uv_seen_r <= 1'b1;
                if (!uv_seen_r || sink_a_now_i < min_r)
                    min_r <= sink_a_now_i;
            end
        end
    end

    // =====================================
    // current code selection
    // =====================================
    // indicator six bits, assist seven
    assign code_a = (ctrl_r[1:0] == `FLD_MODE_IND) ? {2'b00, cur_a_r[5:0]} :
                    (ctrl_r[1:0] == `FLD_MODE_ASSIST) ? {1'b0, cur_a_r[6:0]} : cur_a_r;
    assign code_b = (ctrl_r[1:0] == `FLD_MODE_IND) ? {2'b00, cur_b_r[5:0]} :
                    (ctrl_r[1:0] == `FLD_MODE_ASSIST) ? {1'b0, cur_b_r[6:0]} : cur_b_r;

    fld_scale u_scale_a (
        .code_i(code_a),
        .uplift_i(upl_r),
        .bal_en_i(dim_r[`FLD_DIM_BAL]),
        .trim_i(trim_a_i),
        .code_o(eff_a)
    );

    fld_scale u_scale_b (
        .code_i(code_b),
        .uplift_i(upl_r),
        .bal_en_i(dim_r[`FLD_DIM_BAL]),
        .trim_i(trim_b_i),
        .code_o(eff_b)
    );

    fld_pwm #(
        .SLOT_CYC(SLOT_CYC)
    ) u_pwm (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .duty_i(dim_r[1:0]),
        .gate_o(pwm_gate)
    );

    assign fixf_ok = dim_r[`FLD_DIM_FIXF] && !upl_r &&
                     (ctrl_r[1:0] == `FLD_MODE_FLASH || ctrl_r[1:0] == `FLD_MODE_ASSIST) &&
                     (cur_a_r >= `FLD_FIXF_MIN) && (cur_b_r >= `FLD_FIXF_MIN);

    // =====================================
    // drive outputs
    // =====================================
    // registered drive to the analog side
    always @(posedge clk_i) begin
        if (srst_i) begin
            mode_o <= `FLD_MODE_OFF;
            drive_a_o <= 8'h00;
            drive_b_o <= 8'h00;
            drive_gate_o <= 1'b0;
            skip_allow_o <= 1'b1;
        end else if (ce_i) begin
            mode_o <= ctrl_r[1:0];
            drive_a_o <= eff_a;
            drive_b_o <= eff_b;
            if (ctrl_r[1:0] == `FLD_MODE_IND)
                drive_gate_o <= ctrl_r[3] & pwm_gate;
            else
                drive_gate_o <= ctrl_r[3] & (ctrl_r[1:0] != `FLD_MODE_OFF);
            skip_allow_o <= !fixf_ok;
        end
    end

    // =====================================
    // read data
    // =====================================
    // registered read mux
    always @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= 8'h00;
        end else if (ce_i && rd_i) begin
            case (addr_i)
                `FLD_ADDR_ID: rdata_o <= ID_VALUE;
                `FLD_ADDR_CUR_A: rdata_o <= cur_a_r;
                `FLD_ADDR_CUR_B: rdata_o <= cur_b_r;
                `FLD_ADDR_LOWV: rdata_o <= lowv_o;
                `FLD_ADDR_TIMER: rdata_o <= timer_o;
                `FLD_ADDR_CTRL: rdata_o <= ctrl_r;
                `FLD_ADDR_TRIG: rdata_o <= trig_o;
                `FLD_ADDR_FAULT: rdata_o <= fault_i;
                `FLD_ADDR_DIM: rdata_o <= {dim_r[7:5], s2_r[2] & s2_r[1],
                                           s2_r[2] & s2_r[0], dim_r[2:0]};
                `FLD_ADDR_MIN: rdata_o <= min_r;
                `FLD_ADDR_ACT: rdata_o <= act_r;
                `FLD_ADDR_UPL: rdata_o <= unlock_r ? {7'h00, upl_r} : 8'h00;
                default: rdata_o <= 8'h00;
            endcase
        end
    end
endmodule

// ---- tb/fld_host_model.sv ----
// Purpose: host model issuing register strobes to the bank
// Assumes: strobes taken on rising clk_i, read data valid after that edge
// Notes: address and data are inverted while the bus is idle
`timescale 1ns/1ps
// =======================================
// host access model
module fld_host_model (
    input wire clk_i,           // system clock
    input wire [7:0] rdata_i,   // read data
    output logic [7:0] addr_o,  // register address
    output logic wr_o,          // write strobe
    output logic rd_o,          // read strobe
    output logic [7:0] wdata_o  // write data
);
    // idle bus at start
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end
    // one strobe held over one sampling edge
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        addr_o = a;
        wdata_o = d;
        wr_o = w;
        rd_o = !w;
        @(posedge clk_i);
        #1;
    endtask
    // release: no stale address or data left showing
    task automatic idle;
        wr_o = 1'b0;
        rd_o = 1'b0;
        addr_o = ~addr_o;
        wdata_o = ~wdata_o;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        acc(1'b1, a, d);
        idle;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        acc(1'b0, a, ~a);
        d = rdata_i;
        idle;
    endtask
    task automatic pair(input logic [7:0] wa, input logic [7:0] wd, input logic [7:0] ra,
                        output logic [7:0] d);
        @(posedge clk_i);
        #1;
        acc(1'b1, wa, wd);
        acc(1'b0, ra, ~wd);
        d = rdata_i;
        idle;
    endtask
endmodule

// ---- tb/fld_regs_asserts.sv ----
// Purpose: port level checks of the register bank
// Assumes: single clock domain, sync reset
// Notes: bound to every fld_regs instance
`timescale 1ns/1ps
// =======================================
// checker
module fld_regs_asserts #(
    parameter SLOT_CYC = 250
) (
    input wire clk_i,               // system clock
    input wire srst_i,              // sync reset
    input wire ce_i,                // clock enable
    input wire [7:0] addr_i,        // register address
    input wire wr_i,                // write strobe
    input wire rd_i,                // read strobe
    input wire [7:0] wdata_i,       // write data
    input wire [7:0] rdata_o,       // read data
    input wire [7:0] sink_a_now_i,  // present sink a code
    input wire [1:0] mode_o,        // operating mode
    input wire [7:0] drive_a_o,     // effective code a
    input wire drive_gate_o,        // sink enable
    input wire skip_allow_o,        // pulse skip allowed
    input wire [7:0] lowv_o,        // thresholds
    input wire [7:0] timer_o,       // pulse limit
    input wire [7:0] trig_o         // trigger config
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    int hi_cnt;
    // length of the present gate-high run in indicator mode
    always @(posedge clk_i) begin
        if (srst_i || mode_o != 2'b01 || !drive_gate_o) begin
            hi_cnt <= 0;
        end else if (ce_i) begin
            hi_cnt <= hi_cnt + 1;
        end
    end
    sequence s_key_bad;
        ce_i && wr_i && addr_i == 8'h80 && wdata_i != 8'hA1;
    endsequence
    sequence s_upl_acc;
        ce_i && (wr_i || rd_i) && addr_i == 8'h81;
    endsequence
    sequence s_upl_rd;
        ce_i && rd_i && addr_i == 8'h81;
    endsequence
    chk_key_wrong: assert property (s_key_bad ##1 s_upl_rd |=> rdata_o == 8'h00)
        else $error("locked uplift read not zero");
    chk_unlock_once: assert property (s_upl_acc ##1 s_upl_rd |=> rdata_o == 8'h00)
        else $error("unlock reused");
    chk_act_follow: assert property (ce_i && rd_i && addr_i == 8'h0F && $stable(sink_a_now_i)
        |=> rdata_o == $past(sink_a_now_i, 2)) else $error("present report wrong");
    chk_skip_ind: assert property (!mode_o[1] && !$past(mode_o[1]) |-> skip_allow_o)
        else $error("skip blocked outside flash or assist");
    chk_gate_width: assert property (hi_cnt <= 4 * SLOT_CYC + 1)
        else $error("pwm high run too long");
    chk_rst_vals: assert property (disable iff (1'b0) srst_i && ce_i |=> lowv_o == 8'h2C
        && timer_o == 8'h23 && trig_o == 8'hC0 && mode_o == 2'b00 && skip_allow_o)
        else $error("reset values wrong");
    chk_rdata_hold: assert property (ce_i && !rd_i |=> $stable(rdata_o))
        else $error("read data moved without read");
    chk_ce_freeze: assert property (!ce_i |=> $stable(rdata_o) && $stable(drive_a_o)
        && $stable(mode_o) && $stable(drive_gate_o)) else $error("outputs moved with ce low");
    chk_mode_write: assert property (ce_i && wr_i && addr_i == 8'h06
        |-> ##2 mode_o == $past(wdata_i[1:0], 2)) else $error("mode write not taken");
endmodule
bind fld_regs fld_regs_asserts #(.SLOT_CYC(SLOT_CYC)) u_chk (.clk_i(clk_i), .srst_i(srst_i),
    .ce_i(ce_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i),
    .rdata_o(rdata_o), .sink_a_now_i(sink_a_now_i), .mode_o(mode_o), .drive_a_o(drive_a_o),
    .drive_gate_o(drive_gate_o), .skip_allow_o(skip_allow_o), .lowv_o(lowv_o),
    .timer_o(timer_o), .trig_o(trig_o));

// ---- tb/fld_regs_bench.sv ----
// Purpose: self-checking bench of the register bank
// Assumes: 125 MHz clock, slot length shortened to 4 cycles
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
// =======================================
// bench top
module fld_regs_bench;
    logic clk_i = 0, srst_i = 1, ce_i = 1, a_hi = 0, b_hi = 0, run = 0, uv = 0, cyc = 0;
    logic [7:0] sink = 0, rdata, lowv, timer, trig, drv_a, drv_b, addr, wdata, d;
    logic signed [8:0] trim_a = 0;
    logic [7:0] flt = 8'h00;
    logic [1:0] mode;
    logic gate, skip, wr, rd;
    int errors = 0, checks_done = 0, n;
    // clock
    always #4 clk_i = ~clk_i;
    fld_host_model i_host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
        .rd_o(rd), .wdata_o(wdata));
    fld_regs #(.SLOT_CYC(4)) i_dut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .addr_i(addr),
        .wr_i(wr), .rd_i(rd), .wdata_i(wdata), .rdata_o(rdata), .a_higher_i(a_hi),
        .b_higher_i(b_hi), .conv_run_i(run), .uv_reduce_i(uv), .sink_a_now_i(sink),
        .trim_a_i(trim_a), .trim_b_i(-trim_a), .cycle_start_i(cyc), .fault_i(flt),
        .mode_o(mode), .drive_a_o(drv_a), .drive_b_o(drv_b), .drive_gate_o(gate),
        .skip_allow_o(skip), .lowv_o(lowv), .timer_o(timer), .trig_o(trig));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        i_host.rd(a, d);
        chk(d, e);
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge clk_i);
        #1;
    endtask
    task automatic end_sim;
        if (errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // =======================================
    // scenarios
    task automatic t_reset;
        chk({lowv, timer, trig, mode, skip, gate}, {24'h2C23C0, 4'b0010});
        rc(8'h01, 8'h9C);
        rc(8'h06, 8'h00);
        rc(8'h0E, 8'h00);
        rc(8'h00, 8'h5A);
        i_host.wr(8'h03, 8'h00);
        rc(8'h02, 8'h9C);
        ce_i = 0;
        wt(4);
        i_host.wr(8'h01, 8'h55);
        ce_i = 1;
        rc(8'h01, 8'h9C);
        i_host.wr(8'h04, 8'h15);
        i_host.wr(8'h05, 8'h7F);
        i_host.wr(8'h07, 8'h40);
        chk({lowv, timer, trig}, 24'h157F40);
        rc(8'h05, 8'h7F);
        flt = 8'h91;
        rc(8'h08, 8'h91);
    endtask
    task automatic t_report;
        sink = 8'h37;
        i_host.wr(8'h0F, 8'hFF);
        i_host.wr(8'h0E, 8'hFF);
        i_host.wr(8'h09, 8'h18);
        rc(8'h0F, 8'h37);
        rc(8'h0F, 8'h37);
        rc(8'h0E, 8'h00);
        rc(8'h09, 8'h00);
        run = 1;
        a_hi = 1;
        wt(4);
        rc(8'h09, 8'h08);
        {a_hi, b_hi} = 2'b01;
        wt(4);
        rc(8'h09, 8'h10);
        run = 0;
        wt(4);
        rc(8'h09, 8'h00);
        b_hi = 0;
    endtask
    task automatic t_min;
        cyc = 1;
        wt(1);
        cyc = 0;
        uv = 1;
        sink = 8'h50;
        wt(4);
        sink = 8'h30;
        wt(2);
        sink = 8'h40;
        wt(2);
        uv = 0;
        wt(4);
        sink = 8'h10;
        wt(3);
        rc(8'h0E, 8'h30);
        cyc = 1;
        wt(1);
        cyc = 0;
        rc(8'h0E, 8'h00);
    endtask
    task automatic t_unlock;
        i_host.pair(8'h80, 8'h55, 8'h81, d);
        chk(d, 8'h00);
        i_host.wr(8'h80, 8'hA1);
        i_host.pair(8'h81, 8'h01, 8'h81, d);
        chk(d, 8'h00);
        i_host.wr(8'h80, 8'hA1);
        rc(8'h06, 8'h00);
        rc(8'h81, 8'h01);
        i_host.wr(8'h80, 8'hA1);
        i_host.wr(8'h80, 8'h55);
        rc(8'h81, 8'h00);
    endtask
    task automatic t_drive;
        i_host.wr(8'h01, 8'h90);
        i_host.wr(8'h02, 8'h40);
        i_host.wr(8'h06, 8'h0B);
        wt(3);
        chk({drv_a, drv_b, skip}, {8'h9F, 8'h47, 1'b1});
        i_host.wr(8'h80, 8'hA1);
        i_host.wr(8'h81, 8'h00);
        i_host.wr(8'h09, 8'h04);
        wt(3);
        chk({drv_a, drv_b, skip}, {8'h90, 8'h40, 1'b0});
        i_host.wr(8'h02, 8'h3F);
        wt(3);
        chk(skip, 1'b1);
        i_host.wr(8'h02, 8'h40);
        i_host.wr(8'h09, 8'h24);
        trim_a = 9'sd100;
        wt(3);
        chk({drv_a, drv_b, skip}, {8'h9E, 8'h39, 1'b0});
        i_host.wr(8'h80, 8'hA1);
        i_host.wr(8'h81, 8'h01);
        wt(3);
        chk(skip, 1'b1);
        i_host.wr(8'h80, 8'hA1);
        i_host.wr(8'h81, 8'h00);
        i_host.wr(8'h09, 8'h00);
        wt(3);
        chk({drv_a, drv_b, skip}, {8'h90, 8'h40, 1'b1});
        i_host.wr(8'h06, 8'h09);
        wt(3);
        chk({drv_a, drv_b, skip}, {8'h10, 8'h00, 1'b1});
        i_host.wr(8'h09, 8'h04);
        wt(3);
        chk(skip, 1'b1);
    endtask
    task automatic t_pwm;
        for (int k = 0; k < 4; k++) begin
            i_host.wr(8'h09, k[7:0]);
            wt(70);
            n = 0;
            repeat (256) begin
                @(negedge clk_i);
                n += int'(gate === 1'b1);
            end
            chk(n, (k + 1) * 16);
        end
    endtask
    // watchdog
    initial begin
        #200000;
        errors++;
        end_sim;
    end
    // main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        #1;
        srst_i = 0;
        t_reset;
        t_report;
        t_min;
        t_unlock;
        t_drive;
        t_pwm;
        end_sim;
    end
endmodule
